// file: fom_host_model.sv
// Host controller model that issues command writes to the selection block.
module fom_host_model import fom_pkg::*; (
  // Clock.
  input wire logic clk,
  // Command write and observed pulses.
  output fom_cmd_t cmd,
  input wire logic accept,
  input wire logic start
);
  initial cmd = '0;
  // Holds one write for a single cycle and samples the pulses at the edge that takes it.
  task automatic send(input logic [7:0] code, input logic [3:0] part, output logic [1:0] seen);
    @(negedge clk);
    cmd <= {1'b1, code, part};
    @(posedge clk);
    seen = {accept, start};
    @(negedge clk);
    cmd <= '0;
  endtask : send
endmodule : fom_host_model

// file: fom_output_select.sv
// Output source selection for each partition of a parallel flash command interface.
//
// Contract
// - In setup, load or confirm states every command selects the status word, except a confirm code in lock setup, which selects array contents.
// - From ready, suspended or busy, read-array selects array contents.
// - From those states read-status selects status; identify commands select identification data.
// - From those states the one-time-programmable setup command selects status.
// - Stray lock, lock-down or configuration confirm codes there leave selection unchanged.
// - Clear-status clears error bits only while the write engine is idle and factory programming is not active.
// - Each partition keeps its own selection; chip state ignores it.
// - Factory program data is accepted only while status bit 0 is zero.
// - Lock, unlock, lock-down or configuration confirm performs it, then returns ready.
module fom_output_select
  import fom_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Host command write.
  input fom_cmd_t cmd,
  // Chip state from the write engine.
  input fom_grp_t grp,
  input wire logic engine_busy,
  input wire logic factory_mode,
  input wire logic [7:0] status_in,
  // Selection and status outputs.
  output fom_src_t sel_out [FOM_PARTS],
  output logic [7:0] status_err,
  output logic factory_data_accept,
  output logic lock_op_start
);

  ////////////////////////////////////////////////////////////////////////////

  localparam int SRC_W = $bits(fom_src_t);

  // True for the lock, lock-down and configuration confirm codes.
  function automatic logic fom_is_stray_confirm(logic [7:0] code);
    return code == FOM_CMD_LOCK_CONFIRM
           || code == FOM_CMD_LOCKDOWN_CONFIRM
           || code == FOM_CMD_CONFIG_CONFIRM;
  endfunction : fom_is_stray_confirm

  fom_src_t sel_r [FOM_PARTS];
  fom_src_t sel_nxt;
  logic [SRC_W*FOM_PARTS-1:0] sel_flat;
  logic clear_blocked;
  logic [7:0] err_r;
  logic keep;
  logic clear_ok;

  wire logic is_read_array = cmd.code == FOM_CMD_READ_ARRAY;
  wire logic is_read_status = cmd.code == FOM_CMD_READ_STATUS;
  wire logic is_ident = cmd.code == FOM_CMD_IDENT_A || cmd.code == FOM_CMD_IDENT_B;
  wire logic is_otp = cmd.code == FOM_CMD_OTP_SETUP;
  wire logic is_confirm_lock = fom_is_stray_confirm(cmd.code);
  wire logic is_lock_confirm_any = is_confirm_lock || cmd.code == FOM_CMD_CONFIRM;

  // Decode of the new source; keep means the partition holds its source.
  always_comb begin
    sel_nxt = FOM_SRC_STATUS;
    keep = 1'b0;
    case (grp)
      FOM_GRP_SETUP: sel_nxt = FOM_SRC_STATUS;
      FOM_GRP_LOCK: sel_nxt = is_lock_confirm_any ? FOM_SRC_ARRAY : FOM_SRC_STATUS;
      FOM_GRP_OTP: keep = 1'b1;
      FOM_GRP_IDLE: begin
        if (is_read_array) begin
          sel_nxt = FOM_SRC_ARRAY;
        end else if (is_ident) begin
          sel_nxt = FOM_SRC_IDENT;
        end else if (is_read_status || is_otp) begin
          sel_nxt = FOM_SRC_STATUS;
        end else if (is_confirm_lock) begin
          keep = 1'b1;
        end else begin
          sel_nxt = FOM_SRC_STATUS;
        end
      end
      default: keep = 1'b1;
    endcase
  end

  // One selection per partition, touched only by a write to it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < FOM_PARTS; i++) begin
        sel_r[i] <= FOM_SRC_ARRAY;
      end
    end else if (cmd.valid && !keep) begin
      sel_r[cmd.part] <= sel_nxt;
    end
  end

  assign sel_out = sel_r;

  // Flattened copy of all selections, so that whole-array stability can be checked.
  always_comb begin
    sel_flat = '0;
    for (int i = 0; i < FOM_PARTS; i++) begin
      sel_flat[i*SRC_W +: SRC_W] = sel_r[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Error bits: new errors win over a clear in the same cycle.
  // A clear is ignored while the engine runs or factory programming is active.
  assign clear_blocked = engine_busy || factory_mode;
  assign clear_ok = cmd.valid && cmd.code == FOM_CMD_CLEAR_STATUS && !clear_blocked;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_r <= 8'h00;
    end else if (clear_ok) begin
      err_r <= status_in & FOM_ERR_MASK;
    end else begin
      err_r <= err_r | (status_in & FOM_ERR_MASK);
    end
  end

  assign status_err = err_r;

  // Factory program data gate and lock operation launch.
  assign factory_data_accept = cmd.valid && factory_mode
                               && !status_in[FOM_READY_BIT];
  assign lock_op_start = cmd.valid && grp == FOM_GRP_LOCK && is_lock_confirm_any;

  ////////////////////////////////////////////////////////////////////////////

  property p_setup_status;
    @(posedge clk) disable iff (!reset_n)
    (cmd.valid && grp == FOM_GRP_SETUP) |=> sel_r[$past(cmd.part)] == FOM_SRC_STATUS;
  endproperty
  a_setup_status: assert property (p_setup_status) else $error("setup not status");

  property p_read_array;
    @(posedge clk) disable iff (!reset_n)
    (cmd.valid && grp == FOM_GRP_IDLE && is_read_array)
      |=> sel_r[$past(cmd.part)] == FOM_SRC_ARRAY;
  endproperty
  a_read_array: assert property (p_read_array) else $error("read array missed");

  property p_ident;
    @(posedge clk) disable iff (!reset_n)
    (cmd.valid && grp == FOM_GRP_IDLE && is_ident) |=> sel_r[$past(cmd.part)] == FOM_SRC_IDENT;
  endproperty
  a_ident: assert property (p_ident) else $error("ident missed");

  property p_otp;
    @(posedge clk) disable iff (!reset_n)
    (cmd.valid && grp == FOM_GRP_IDLE && is_otp) |=> sel_r[$past(cmd.part)] == FOM_SRC_STATUS;
  endproperty
  a_otp: assert property (p_otp) else $error("otp setup not status");

  property p_stray;
    @(posedge clk) disable iff (!reset_n)
    (cmd.valid && grp == FOM_GRP_IDLE && is_confirm_lock)
      |=> sel_r[$past(cmd.part)] == $past(sel_r[cmd.part]);
  endproperty
  a_stray: assert property (p_stray) else $error("stray confirm changed source");

  property p_clear_busy;
    @(posedge clk) disable iff (!reset_n)
    engine_busy |=> (err_r & $past(err_r)) == $past(err_r);
  endproperty
  a_clear_busy: assert property (p_clear_busy) else $error("errors lost while busy");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
    !cmd.valid |=> $stable(sel_flat);
  endproperty
  a_hold: assert property (p_hold) else $error("source moved without command");

  // A write while the one-time-programmable operation runs.
  sequence s_otp_write;
    cmd.valid && grp == FOM_GRP_OTP;
  endsequence

  // A write in lock setup that is not one of the confirm codes.
  sequence s_lock_other;
    cmd.valid && grp == FOM_GRP_LOCK && !is_lock_confirm_any;
  endsequence

  // A clear-status write while clearing is not allowed.
  sequence s_clear_blocked;
    cmd.valid && cmd.code == FOM_CMD_CLEAR_STATUS && clear_blocked;
  endsequence

  property p_otp_keep;
    @(posedge clk) disable iff (!reset_n)
    s_otp_write |=> $stable(sel_flat);
  endproperty
  a_otp_keep: assert property (p_otp_keep) else $error("source moved in otp busy");

  property p_lock_other;
    @(posedge clk) disable iff (!reset_n)
    s_lock_other |=> sel_r[$past(cmd.part)] == FOM_SRC_STATUS;
  endproperty
  a_lock_other: assert property (p_lock_other) else $error("lock setup not status");

  property p_clear_idle;
    @(posedge clk) disable iff (!reset_n)
    clear_ok |=> err_r == ($past(status_in) & FOM_ERR_MASK);
  endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("clear did not clear");

  property p_clear_blocked;
    @(posedge clk) disable iff (!reset_n)
    s_clear_blocked |=> (err_r & $past(err_r)) == $past(err_r);
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) else $error("blocked clear lost errors");

  property p_factory_open;
    @(posedge clk) disable iff (!reset_n)
    (cmd.valid && factory_mode && !status_in[FOM_READY_BIT]) |-> factory_data_accept;
  endproperty
  a_factory_open: assert property (p_factory_open) else $error("factory data dropped");

  property p_factory;
    @(posedge clk) disable iff (!reset_n)
    status_in[FOM_READY_BIT] |-> !factory_data_accept;
  endproperty
  a_factory: assert property (p_factory) else $error("factory data taken");

  property p_lock;
    @(posedge clk) disable iff (!reset_n)
    lock_op_start |=> sel_r[$past(cmd.part)] == FOM_SRC_ARRAY;
  endproperty
  a_lock: assert property (p_lock) else $error("lock confirm source wrong");

endmodule : fom_output_select

// file: fom_output_select_tb.sv
// Testbench for the flash output source selection block.
module fom_output_select_tb import fom_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  fom_cmd_t cmd;
  fom_grp_t grp = FOM_GRP_IDLE;
  logic engine_busy = 1'b0;
  logic factory_mode = 1'b0;
  logic [7:0] status_in = 8'h00;
  fom_src_t sel_out [FOM_PARTS];
  logic [7:0] status_err;
  logic factory_data_accept;
  logic lock_op_start;
  logic [1:0] seen;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  fom_output_select dut_u (.clk(clk), .reset_n(reset_n), .cmd(cmd), .grp(grp),
    .engine_busy(engine_busy), .factory_mode(factory_mode), .status_in(status_in),
    .sel_out(sel_out), .status_err(status_err), .factory_data_accept(factory_data_accept),
    .lock_op_start(lock_op_start));
  fom_host_model host_u (.clk(clk), .cmd(cmd), .accept(factory_data_accept),
    .start(lock_op_start));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [3:0] p);
    host_u.send(c, p, seen);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    logic [7:0] codes [6] = '{8'h70, 8'hff, 8'h90, 8'hc0, 8'h98, 8'hff};
    logic [1:0] exps [6] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h3, 2'h0};
    for (int p = 0; p < FOM_PARTS; p++) begin
      chk("sel_reset", 8'h00, {6'h0, sel_out[p]});
    end
    for (int i = 0; i < 6; i++) begin
      wr(codes[i], 4'h3);
      chk("sel_idle", {6'h0, exps[i]}, {6'h0, sel_out[3]});
    end
    wr(8'h90, 4'h5);
    for (int i = 0; i < 3; i++) begin
      wr(i == 0 ? 8'h01 : (i == 1 ? 8'h2f : 8'h03), 4'h5);
      chk("sel_stray", 8'h03, {6'h0, sel_out[5]});
    end
    repeat (5) @(negedge clk);
    chk("sel_hold", 8'h03, {6'h0, sel_out[5]});
    chk("sel_other", 8'h00, {6'h0, sel_out[3]});
  endtask : t_idle
  task automatic t_setup_lock();
    @(negedge clk);
    grp = FOM_GRP_SETUP;
    wr(8'hff, 4'h6);
    chk("sel_setup", 8'h01, {6'h0, sel_out[6]});
    grp = FOM_GRP_LOCK;
    wr(8'h01, 4'h6);
    chk("lock_start", 8'h01, {7'h0, seen[0]});
    chk("sel_lock", 8'h00, {6'h0, sel_out[6]});
    wr(8'h60, 4'h6);
    chk("sel_lock_other", 8'h01, {6'h0, sel_out[6]});
    grp = FOM_GRP_OTP;
    wr(8'hff, 4'h6);
    chk("sel_otp", 8'h01, {6'h0, sel_out[6]});
    grp = FOM_GRP_IDLE;
  endtask : t_setup_lock
  task automatic t_clear_factory();
    @(negedge clk);
    status_in = 8'hff;
    @(negedge clk);
    status_in = 8'h00;
    engine_busy = 1'b1;
    wr(8'h50, 4'h0);
    chk("err_busy", 8'h3a, status_err);
    engine_busy = 1'b0;
    wr(8'h50, 4'h0);
    chk("err_idle", 8'h00, status_err);
    factory_mode = 1'b1;
    wr(8'h12, 4'h9);
    chk("accept", 8'h01, {7'h0, seen[1]});
    status_in = 8'h01;
    wr(8'h12, 4'h9);
    chk("refuse", 8'h00, {7'h0, seen[1]});
    status_in = 8'h02;
    @(negedge clk);
    status_in = 8'h01;
    wr(8'h50, 4'h0);
    chk("err_factory", 8'h02, status_err);
    factory_mode = 1'b0;
  endtask : t_clear_factory
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    t_idle();
    t_setup_lock();
    t_clear_factory();
    give_verdict();
  end
endmodule : fom_output_select_tb

// file: fom_pkg.sv
// Package for the flash output source selection block.
package fom_pkg;

  // Output source of read cycles.
  typedef enum logic [1:0] {
    FOM_SRC_ARRAY  = 2'h0,
    FOM_SRC_STATUS = 2'h1,
    FOM_SRC_IDENT  = 2'h3
  } fom_src_t;

  // Chip state group as reported by the write engine.
  typedef enum logic [1:0] {
    FOM_GRP_SETUP = 2'h0,
    FOM_GRP_LOCK  = 2'h1,
    FOM_GRP_OTP   = 2'h3,
    FOM_GRP_IDLE  = 2'h2
  } fom_grp_t;

  // Command write from the host.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [3:0] part;
  } fom_cmd_t;

  localparam int FOM_PARTS = 16;
  localparam logic [7:0] FOM_CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] FOM_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FOM_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FOM_CMD_IDENT_A = 8'h90;
  localparam logic [7:0] FOM_CMD_IDENT_B = 8'h98;
  localparam logic [7:0] FOM_CMD_OTP_SETUP = 8'hc0;
  localparam logic [7:0] FOM_CMD_LOCK_CONFIRM = 8'h01;
  localparam logic [7:0] FOM_CMD_LOCKDOWN_CONFIRM = 8'h2f;
  localparam logic [7:0] FOM_CMD_CONFIG_CONFIRM = 8'h03;
  localparam logic [7:0] FOM_CMD_SETUP_PROGRAM_A = 8'h10;
  localparam logic [7:0] FOM_CMD_SETUP_PROGRAM_B = 8'h40;
  localparam logic [7:0] FOM_CMD_SETUP_BUFFERED = 8'he8;
  localparam logic [7:0] FOM_CMD_SETUP_ERASE = 8'h20;
  localparam logic [7:0] FOM_CMD_SETUP_FACTORY = 8'h30;
  localparam logic [7:0] FOM_CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] FOM_CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] FOM_CMD_LOCK_SETUP = 8'h60;
  localparam int FOM_READY_BIT = 0;
  localparam logic [7:0] FOM_ERR_MASK = 8'h3a;
  localparam logic [7:0] FOM_STATUS_RESET = 8'h80;

endpackage : fom_pkg
